// file: include/cgr_pkg.sv
// constants for the clock generator control byte bank
// assumes: byte-wide index/data port driven by a serial protocol engine on clk_in
package cgr_pkg;

  // register indices (bank byte offsets)
  localparam logic [6:0] IDX_SPREAD_AUX_CFG  = 7'h01;
  localparam logic [6:0] IDX_REF_USB_OE      = 7'h02;
  localparam logic [6:0] IDX_RESERVED_THREE  = 7'h03;
  localparam logic [6:0] IDX_DIFF_OE_SPREAD  = 7'h04;
  localparam logic [6:0] IDX_RESERVED_FIVE   = 7'h05;
  localparam logic [6:0] IDX_SLEW_MIDDLE     = 7'h06;
  localparam logic [6:0] IDX_MAKER_REVISION  = 7'h07;
  localparam logic [6:0] IDX_PART_VIDEO_OE   = 7'h08;
  localparam logic [6:0] IDX_TEST_AMPLITUDE  = 7'h09;

  // power-up values, byte 9 leftmost down to byte 1
  localparam logic [9:1][7:0] BYTE_RESET = {8'h25, 8'h03, 8'h00, 8'h00, 8'h00,
                                            8'hFF, 8'hFF, 8'hFF, 8'h85};
  // host-writable bits; all other bits keep their power-up value
  localparam logic [9:1][7:0] WRITE_MASK = {8'h1F, 8'h03, 8'h00, 8'h28, 8'h00,
                                            8'h7F, 8'h00, 8'hC0, 8'h7E};
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // byte 1 fields
  localparam int BIT_MAIN_SPREAD_TYPE = 6;
  localparam int BIT_AUX_SPREAD_TYPE  = 5;
  localparam int AUX_CFG_MSB          = 4;
  localparam int AUX_CFG_LSB          = 1;
  localparam logic [3:0] AUX_CFG_RESET = 4'h2;
  // byte 2 fields
  localparam int BIT_REF_OE   = 7;
  localparam int BIT_USB48_OE = 6;
  // byte 4 fields
  localparam int BIT_STORAGE_OE     = 6;
  localparam int BIT_SERIAL_LINK_OE = 5;
  localparam int BIT_VIDEO96_OE     = 4;
  localparam int BIT_PROC_B_OE      = 3;
  localparam int BIT_PROC_A_OE      = 2;
  localparam int BIT_MAIN_SPREAD_EN = 1;
  localparam int BIT_AUX_SPREAD_EN  = 0;
  // byte 6 fields
  localparam int BIT_SLEW_REF_MID     = 5;
  localparam int BIT_SLEW_VIDEO27_MID = 3;
  // byte 8 fields
  localparam int BIT_VIDEO27_STEADY_OE = 1;
  localparam int BIT_VIDEO27_SPREAD_OE = 0;
  // byte 9 fields
  localparam int BIT_TEST_SELECT = 4;
  localparam int BIT_TEST_ENTRY  = 3;
  localparam int AMP_MSB         = 2;

  // positions in the output-enable vector
  localparam int OE_COUNT          = 9;
  localparam int OE_REF            = 0;
  localparam int OE_USB48          = 1;
  localparam int OE_STORAGE        = 2;
  localparam int OE_SERIAL_LINK    = 3;
  localparam int OE_VIDEO96        = 4;
  localparam int OE_PROC_B         = 5;
  localparam int OE_PROC_A         = 6;
  localparam int OE_VIDEO27_STEADY = 7;
  localparam int OE_VIDEO27_SPREAD = 8;
  localparam logic [8:0] OE_RESET  = 9'h1FF;

endpackage

// file: include/cgr_gate_if.sv
// carrier between the control bank and the output-enable gate
// assumes: both ends run on clk_in
`timescale 1ns/1ns
interface cgr_gate_if;
  logic [8:0] req;        // enables as written by the host
  logic [8:0] idle_raw;   // per-output low-phase level, from the clock domains
  logic [8:0] run;        // enables actually applied

  modport ctrl (output req, output idle_raw, input run);
  modport gate (input req, input idle_raw, output run);
endinterface

// file: rtl/cgr_oe_gate.sv
// per-output enable gate that only switches while the output is low
// assumes: idle_raw comes from foreign clocks and is synchronised here
`timescale 1ns/1ns
module cgr_oe_gate (
  input wire logic clk_in,
  input wire logic resetn_in,
  cgr_gate_if.gate gif
);

  logic [8:0] idle_meta;
  logic [8:0] idle_sync;
  logic [8:0] run;
  logic [8:0] next_run;

  assign gif.run = run;

  genvar i;
  generate
    for (i = 0; i < cgr_pkg::OE_COUNT; i++)
    begin : g_bit
      // two-stage synchroniser for the low-phase level
      always_ff @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          idle_meta[i] <= 1'b0;
          idle_sync[i] <= 1'b0;
        end
        else
        begin
          idle_meta[i] <= gif.idle_raw[i];
          idle_sync[i] <= idle_meta[i];
        end
      end

      // take the new enable only in the low phase, stopping the output low
      always_comb
      begin
        next_run[i] = idle_sync[i] ? gif.req[i] : run[i];
      end

      always_ff @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
          run[i] <= cgr_pkg::OE_RESET[i];
        else
          run[i] <= next_run[i];
      end

      a_gate_low_only: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (run[i] != $past(run[i])) |-> $past(idle_sync[i]))
        else $error("enable switched outside the low phase");

      a_gate_follows_req: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (idle_sync[i] && gif.req[i] != run[i]) |=> (run[i] == $past(gif.req[i])))
        else $error("enable did not follow request in low phase");
    end
  endgenerate

endmodule

// file: rtl/cgr_ctrl_bank.sv
// control byte bank 1 to 9 of the clock synthesizer, with output enable gating
// assumes: byte port driven by the serial protocol engine on clk_in,
// main_src_source_select_in from byte 0 on clk_in, clk_low_in from output clocks
//
// Behaviour
// - byte1 bits 6/5 pick down (0) or center (1) spread, main/aux synth.
// - aux config code byte1[4:1] applied only while main source select is 0.
// - byte2 bit7 enables the reference output, default on.
// - byte2 bit6 enables the 48MHz output, default on.
// - byte4 bits 6,5,4 enable storage, serial link, video96 clocks, default on.
// - byte4 bits 3,2 enable processor clocks b and a, default on.
// - byte4 bit1 turns main synth spread on, default on.
// - byte4 bit0 turns aux synth spread on, default on.
// - byte6 bit5 is reference slew middle bit, 1 low, default 0.
// - byte6 bit3 is 27MHz slew middle bit, 1 low, default 0.
// - byte8 bits 1,0 enable steady and spread 27MHz outputs, default on.
// - byte9 bit3 enters test mode, default normal operation.
// - in test mode byte9 bit4 picks tri-state (0) or divided reference (1).
// - byte9 bits 2:0 set differential amplitude, default code 101.
// - every register loads its default at power-up before any access.
// - main source select 0 picks main synth, 1 aux; gates aux config.
`timescale 1ns/1ns
module cgr_ctrl_bank #(
  parameter logic [3:0] REVISION_CODE = 4'h3,  // arbitrary value
  parameter logic [3:0] VENDOR_CODE   = 4'h5,  // arbitrary value
  parameter logic [3:0] PART_CODE     = 4'h6   // arbitrary value
) (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [6:0] reg_index_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       main_src_source_select_in,
  input  wire logic [8:0] clk_low_in,
  output logic      [7:0] reg_rdata_out,
  output logic            reg_rvalid_out,
  output logic            main_synth_spread_type_out,
  output logic            aux_synth_spread_type_out,
  output logic      [3:0] aux_synth_config_code_out,
  output logic            main_synth_spread_enable_out,
  output logic            aux_synth_spread_enable_out,
  output logic      [8:0] output_enable_out,
  output logic            slew_ref_mid_out,
  output logic            slew_video27_mid_out,
  output logic            test_mode_out,
  output logic            test_tristate_out,
  output logic            test_refdiv_out,
  output logic      [2:0] diff_amplitude_code_out
);

  // register bank and its next value
  logic [9:1][7:0] bank;
  logic [9:1][7:0] next_bank;
  // applied aux config code
  logic [3:0]      aux_cfg;
  logic [3:0]      next_aux_cfg;
  // test-mode output flags
  logic            tristate;
  logic            next_tristate;
  logic            refdiv;
  logic            next_refdiv;
  // read port
  logic [7:0]      rdata;
  logic [7:0]      next_rdata;
  logic            rvalid;
  logic            next_rvalid;
  // enable request vector handed to the gate
  logic [8:0]      oe_req;

  cgr_gate_if gif ();

  // write path: only writable bits change, reserved bits keep reset value
  always_comb
  begin
    next_bank = bank;
    for (int b = 1; b <= 9; b++)
    begin
      if (reg_wr_in && reg_index_in == 7'(b))
        next_bank[b] = (reg_wdata_in & cgr_pkg::WRITE_MASK[b])
                     | (bank[b] & ~cgr_pkg::WRITE_MASK[b]);
    end
  end

  // bank storage loads defaults at reset
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      bank <= cgr_pkg::BYTE_RESET;
    else
      bank <= next_bank;
  end

  // aux config follows byte 1 only while main synth feeds the link clock
  always_comb
  begin
    if (!main_src_source_select_in)
      next_aux_cfg = next_bank[cgr_pkg::IDX_SPREAD_AUX_CFG]
                              [cgr_pkg::AUX_CFG_MSB:cgr_pkg::AUX_CFG_LSB];
    else
      next_aux_cfg = aux_cfg;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      aux_cfg <= cgr_pkg::AUX_CFG_RESET;
    else
      aux_cfg <= next_aux_cfg;
  end

  // test-mode flags from byte 9
  always_comb
  begin
    next_tristate = next_bank[cgr_pkg::IDX_TEST_AMPLITUDE][cgr_pkg::BIT_TEST_ENTRY]
                  & ~next_bank[cgr_pkg::IDX_TEST_AMPLITUDE][cgr_pkg::BIT_TEST_SELECT];
    next_refdiv   = next_bank[cgr_pkg::IDX_TEST_AMPLITUDE][cgr_pkg::BIT_TEST_ENTRY]
                  & next_bank[cgr_pkg::IDX_TEST_AMPLITUDE][cgr_pkg::BIT_TEST_SELECT];
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tristate <= 1'b0;
      refdiv   <= 1'b0;
    end
    else
    begin
      tristate <= next_tristate;
      refdiv   <= next_refdiv;
    end
  end

  // read mux: ids are fixed, unmapped indices read zero
  always_comb
  begin
    next_rdata  = rdata;
    next_rvalid = reg_rd_in;
    if (reg_rd_in)
    begin
      if (reg_index_in == cgr_pkg::IDX_MAKER_REVISION)
        next_rdata = {REVISION_CODE, VENDOR_CODE};
      else if (reg_index_in == cgr_pkg::IDX_PART_VIDEO_OE)
        next_rdata = {PART_CODE, bank[cgr_pkg::IDX_PART_VIDEO_OE][3:0]};
      else if (reg_index_in >= cgr_pkg::IDX_SPREAD_AUX_CFG
               && reg_index_in <= cgr_pkg::IDX_TEST_AMPLITUDE)
        next_rdata = bank[reg_index_in[3:0]];
      else
        next_rdata = cgr_pkg::UNMAPPED_READ;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rdata  <= cgr_pkg::UNMAPPED_READ;
      rvalid <= 1'b0;
    end
    else
    begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // collect enable requests in output-vector order
  always_comb
  begin
    oe_req = '0;
    oe_req[cgr_pkg::OE_REF]            = bank[cgr_pkg::IDX_REF_USB_OE][cgr_pkg::BIT_REF_OE];
    oe_req[cgr_pkg::OE_USB48]          = bank[cgr_pkg::IDX_REF_USB_OE][cgr_pkg::BIT_USB48_OE];
    oe_req[cgr_pkg::OE_STORAGE]        =
      bank[cgr_pkg::IDX_DIFF_OE_SPREAD][cgr_pkg::BIT_STORAGE_OE];
    oe_req[cgr_pkg::OE_SERIAL_LINK]    =
      bank[cgr_pkg::IDX_DIFF_OE_SPREAD][cgr_pkg::BIT_SERIAL_LINK_OE];
    oe_req[cgr_pkg::OE_VIDEO96]        =
      bank[cgr_pkg::IDX_DIFF_OE_SPREAD][cgr_pkg::BIT_VIDEO96_OE];
    oe_req[cgr_pkg::OE_PROC_B]         =
      bank[cgr_pkg::IDX_DIFF_OE_SPREAD][cgr_pkg::BIT_PROC_B_OE];
    oe_req[cgr_pkg::OE_PROC_A]         =
      bank[cgr_pkg::IDX_DIFF_OE_SPREAD][cgr_pkg::BIT_PROC_A_OE];
    oe_req[cgr_pkg::OE_VIDEO27_STEADY] =
      bank[cgr_pkg::IDX_PART_VIDEO_OE][cgr_pkg::BIT_VIDEO27_STEADY_OE];
    oe_req[cgr_pkg::OE_VIDEO27_SPREAD] =
      bank[cgr_pkg::IDX_PART_VIDEO_OE][cgr_pkg::BIT_VIDEO27_SPREAD_OE];
  end

  // hand requests to the low-phase gate
  assign gif.req      = oe_req;
  assign gif.idle_raw = clk_low_in;

  cgr_oe_gate u_gate (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .gif       (gif.gate)
  );

  // outputs, each straight from a flop
  assign reg_rdata_out                = rdata;
  assign reg_rvalid_out               = rvalid;
  assign main_synth_spread_type_out   =
    bank[cgr_pkg::IDX_SPREAD_AUX_CFG][cgr_pkg::BIT_MAIN_SPREAD_TYPE];
  assign aux_synth_spread_type_out    =
    bank[cgr_pkg::IDX_SPREAD_AUX_CFG][cgr_pkg::BIT_AUX_SPREAD_TYPE];
  assign aux_synth_config_code_out    = aux_cfg;
  assign main_synth_spread_enable_out =
    bank[cgr_pkg::IDX_DIFF_OE_SPREAD][cgr_pkg::BIT_MAIN_SPREAD_EN];
  assign aux_synth_spread_enable_out  =
    bank[cgr_pkg::IDX_DIFF_OE_SPREAD][cgr_pkg::BIT_AUX_SPREAD_EN];
  assign output_enable_out            = gif.run;
  assign slew_ref_mid_out             =
    bank[cgr_pkg::IDX_SLEW_MIDDLE][cgr_pkg::BIT_SLEW_REF_MID];
  assign slew_video27_mid_out         =
    bank[cgr_pkg::IDX_SLEW_MIDDLE][cgr_pkg::BIT_SLEW_VIDEO27_MID];
  assign test_mode_out                =
    bank[cgr_pkg::IDX_TEST_AMPLITUDE][cgr_pkg::BIT_TEST_ENTRY];
  assign test_tristate_out            = tristate;
  assign test_refdiv_out              = refdiv;
  assign diff_amplitude_code_out      =
    bank[cgr_pkg::IDX_TEST_AMPLITUDE][cgr_pkg::AMP_MSB:0];

  // checks
  a_main_spread_type: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_wr_in && reg_index_in == cgr_pkg::IDX_SPREAD_AUX_CFG)
    |=> (main_synth_spread_type_out == $past(reg_wdata_in[6])
         && aux_synth_spread_type_out == $past(reg_wdata_in[5])))
    else $error("spread type bits not taken from byte 1");

  a_aux_cfg_apply: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_wr_in && reg_index_in == cgr_pkg::IDX_SPREAD_AUX_CFG && !main_src_source_select_in)
    |=> (aux_synth_config_code_out == $past(reg_wdata_in[4:1])))
    else $error("aux config not applied while main source selected");

  a_aux_cfg_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    main_src_source_select_in |=> $stable(aux_synth_config_code_out))
    else $error("aux config changed while aux source selected");

  a_proc_oe_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_wr_in && reg_index_in == cgr_pkg::IDX_DIFF_OE_SPREAD)
    |=> (oe_req[cgr_pkg::OE_PROC_A] == $past(reg_wdata_in[2])
         && oe_req[cgr_pkg::OE_PROC_B] == $past(reg_wdata_in[3])
         && aux_synth_spread_enable_out == $past(reg_wdata_in[0])))
    else $error("byte 4 enables not stored");

  a_reserved_three: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_rd_in && reg_index_in == cgr_pkg::IDX_RESERVED_THREE)
    |=> (reg_rvalid_out && reg_rdata_out == 8'hFF))
    else $error("reserved byte 3 read wrong value");

  a_reserved_bits_b1: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_rd_in && reg_index_in == cgr_pkg::IDX_SPREAD_AUX_CFG)
    |=> (reg_rdata_out[7] && reg_rdata_out[0]))
    else $error("byte 1 reserved bits not read as one");

  a_ident_read: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_rd_in && reg_index_in == cgr_pkg::IDX_MAKER_REVISION)
    |=> (reg_rdata_out == {REVISION_CODE, VENDOR_CODE}))
    else $error("identity byte read wrong value");

  a_test_exclusive: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !(test_tristate_out && test_refdiv_out)
    && ((test_tristate_out || test_refdiv_out) == test_mode_out))
    else $error("test mode flags inconsistent");

  a_amp_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_wr_in && reg_index_in == cgr_pkg::IDX_TEST_AMPLITUDE)
    |=> (diff_amplitude_code_out == $past(reg_wdata_in[2:0])))
    else $error("amplitude code not taken from byte 9");

  a_slew_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_wr_in && reg_index_in == cgr_pkg::IDX_SLEW_MIDDLE)
    |=> (slew_ref_mid_out == $past(reg_wdata_in[5])
         && slew_video27_mid_out == $past(reg_wdata_in[3])))
    else $error("slew middle bits not taken from byte 6");

  a_ref_usb_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_wr_in && reg_index_in == cgr_pkg::IDX_REF_USB_OE)
    |=> (oe_req[cgr_pkg::OE_REF] == $past(reg_wdata_in[7])))
    else $error("reference enable request not taken from byte 2");

  a_usb48_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_wr_in && reg_index_in == cgr_pkg::IDX_REF_USB_OE)
    |=> (oe_req[cgr_pkg::OE_USB48] == $past(reg_wdata_in[6])))
    else $error("48MHz enable request not taken from byte 2");

  a_diff_oe_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_wr_in && reg_index_in == cgr_pkg::IDX_DIFF_OE_SPREAD)
    |=> (oe_req[cgr_pkg::OE_STORAGE] == $past(reg_wdata_in[6])
         && oe_req[cgr_pkg::OE_SERIAL_LINK] == $past(reg_wdata_in[5])
         && oe_req[cgr_pkg::OE_VIDEO96] == $past(reg_wdata_in[4])))
    else $error("differential enable requests not taken from byte 4");

  a_main_spread_en: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_wr_in && reg_index_in == cgr_pkg::IDX_DIFF_OE_SPREAD)
    |=> (main_synth_spread_enable_out == $past(reg_wdata_in[1])))
    else $error("main spread enable not taken from byte 4");

  a_video27_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_wr_in && reg_index_in == cgr_pkg::IDX_PART_VIDEO_OE)
    |=> (oe_req[cgr_pkg::OE_VIDEO27_STEADY] == $past(reg_wdata_in[1])
         && oe_req[cgr_pkg::OE_VIDEO27_SPREAD] == $past(reg_wdata_in[0])))
    else $error("video enable requests not taken from byte 8");

  a_test_entry: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_wr_in && reg_index_in == cgr_pkg::IDX_TEST_AMPLITUDE)
    |=> (test_mode_out == $past(reg_wdata_in[3])
         && test_refdiv_out == $past(reg_wdata_in[3] & reg_wdata_in[4])))
    else $error("test mode entry not taken from byte 9");

  a_read_valid: assert property (@(posedge clk_in) disable iff (!resetn_in)
    reg_rvalid_out == $past(reg_rd_in))
    else $error("read valid not one cycle after read strobe");

  a_rdata_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");

  a_unmapped_read: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_rd_in && (reg_index_in == 7'h00 || reg_index_in > cgr_pkg::IDX_TEST_AMPLITUDE))
    |=> (reg_rdata_out == cgr_pkg::UNMAPPED_READ))
    else $error("unmapped index did not read zero");

  a_ignored_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_wr_in && (reg_index_in == 7'h00 || reg_index_in == cgr_pkg::IDX_RESERVED_THREE
                   || reg_index_in == cgr_pkg::IDX_RESERVED_FIVE
                   || reg_index_in == cgr_pkg::IDX_MAKER_REVISION
                   || reg_index_in > cgr_pkg::IDX_TEST_AMPLITUDE))
    |=> $stable(bank))
    else $error("write to a read-only or unmapped index changed the bank");

  a_reserved_b2: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_rd_in && reg_index_in == cgr_pkg::IDX_REF_USB_OE)
    |=> ((reg_rdata_out & ~cgr_pkg::WRITE_MASK[2])
         == (cgr_pkg::BYTE_RESET[2] & ~cgr_pkg::WRITE_MASK[2])))
    else $error("byte 2 reserved bits not read at power-up value");

  a_part_read: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (reg_rd_in && reg_index_in == cgr_pkg::IDX_PART_VIDEO_OE)
    |=> (reg_rdata_out[7:4] == PART_CODE))
    else $error("part code nibble read wrong value");

endmodule

// file: test/cgr_clk_phase_model.sv
// phase source for the nine output clocks: reports which outputs sit low
// assumes: mode 0 holds every output high, 1 holds all low, 2 runs free
`timescale 1ns/1ns
module cgr_clk_phase_model (
  input  wire logic       clk_in,
  input  wire logic [1:0] mode_in,
  output logic      [8:0] clk_low_out
);
  logic [7:0] count;

  // defined level before the first edge
  initial
  begin
    count = 8'h00;
    clk_low_out = 9'h000;
  end

  // each output takes one of five counter bits (index mod 5), so low phases are spread out
  always @(posedge clk_in)
  begin
    count <= count + 8'h01;
    for (int k = 0; k < 9; k++)
      clk_low_out[k] <= (mode_in == 2'h1) | ((mode_in == 2'h2) & count[k % 5]);
  end
endmodule

// file: test/clock_generator_control_registers_tb_top.sv
// bench for the control byte bank: reference model, phase model, random bytes
// assumes: package and interface compiled first; one 25 MHz clock
`timescale 1ns/1ns
module clock_generator_control_registers_tb_top;
  logic       clk_in = 1'b0;
  logic       resetn_in = 1'b0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [6:0] idx = 7'h00;
  logic [7:0] wdata = 8'h00;
  logic       sel = 1'b0;
  logic [1:0] phase_mode = 2'h1;
  logic [8:0] clk_low;
  logic [7:0] rdata;
  logic       rvalid, mtype, atype, men, aen, slr, slv, tm, tts, trd;
  logic [3:0] acode;
  logic [8:0] oe;
  logic [2:0] amp;
  int         miscompares = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         seed = 92367;
  int         rv;
  int         maux;
  int         m[1:9];
  int         rst_val[1:9] = '{8'h85, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h35, 8'h63, 8'h25};
  int         wmask[1:9] = '{8'h7E, 8'hC0, 8'h00, 8'h7F, 8'h00, 8'h28, 8'h00, 8'h03, 8'h1F};

  always #20 clk_in = ~clk_in;

  cgr_clk_phase_model i_cgr_clk_phase_model (
    .clk_in      (clk_in),
    .mode_in     (phase_mode),
    .clk_low_out (clk_low)
  );

  // identity codes are arbitrary values
  cgr_ctrl_bank #(.REVISION_CODE(4'h3), .VENDOR_CODE(4'h5), .PART_CODE(4'h6)) i_cgr_ctrl_bank (
    .clk_in                       (clk_in),
    .resetn_in                    (resetn_in),
    .reg_wr_in                    (wr),
    .reg_rd_in                    (rd),
    .reg_index_in                 (idx),
    .reg_wdata_in                 (wdata),
    .main_src_source_select_in    (sel),
    .clk_low_in                   (clk_low),
    .reg_rdata_out                (rdata),
    .reg_rvalid_out               (rvalid),
    .main_synth_spread_type_out   (mtype),
    .aux_synth_spread_type_out    (atype),
    .aux_synth_config_code_out    (acode),
    .main_synth_spread_enable_out (men),
    .aux_synth_spread_enable_out  (aen),
    .output_enable_out            (oe),
    .slew_ref_mid_out             (slr),
    .slew_video27_mid_out         (slv),
    .test_mode_out                (tm),
    .test_tristate_out            (tts),
    .test_refdiv_out              (trd),
    .diff_amplitude_code_out      (amp)
  );

  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // enables expected from the model bytes
  function automatic logic [8:0] model_oe();
    return {m[8][0], m[8][1], m[4][2], m[4][3], m[4][4], m[4][5], m[4][6], m[2][6], m[2][7]};
  endfunction

  task automatic check_fields();
    check("main type", mtype, m[1][6]);
    check("aux type", atype, m[1][5]);
    check("aux code", acode, maux);
    check("main spread", men, m[4][1]);
    check("aux spread", aen, m[4][0]);
    check("slew ref", slr, m[6][5]);
    check("slew video", slv, m[6][3]);
    check("test mode", tm, m[9][3]);
    check("tristate", tts, m[9][3] & ~m[9][4]);
    check("refdiv", trd, m[9][3] & m[9][4]);
    check("amplitude", amp, m[9] & 7);
  endtask

  // one byte write, fields compared right after the taking edge
  task automatic wr_byte(input logic [6:0] i, input logic [7:0] d, input logic s);
    @(posedge clk_in);
    wr <= 1'b1;
    idx <= i;
    wdata <= d;
    sel <= s;
    @(posedge clk_in);
    wr <= 1'b0;
    if (i >= 1 && i <= 9)
      m[i] = (m[i] & ~wmask[i]) | (d & wmask[i]);
    if (!s)
      maux = (m[1] >> 1) & 15;
    #1;
    check_fields();
  endtask

  // one byte read, answer compared right after the taking edge
  task automatic rd_byte(input logic [6:0] i);
    @(posedge clk_in);
    rd <= 1'b1;
    idx <= i;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    check("rvalid", rvalid, 1);
    check("rdata", rdata, (i >= 1 && i <= 9) ? m[i] : 0);
  endtask

  task automatic read_all();
    for (int k = 1; k <= 12; k++)
      rd_byte(k[6:0]);
    @(posedge clk_in);
    #1;
    check("rvalid drop", rvalid, 0);
  endtask

  // wait a bounded time for the gated enables to settle
  task automatic wait_oe();
    for (int n = 0; n < 40 && oe !== model_oe(); n++)
      @(posedge clk_in);
    #1;
    check("enables", oe, model_oe());
  endtask

  task automatic do_reset();
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    for (int k = 1; k <= 9; k++)
      m[k] = rst_val[k];
    maux = 2;
    #1;
    check("reset enables", oe, 9'h1FF);
    check("reset rdata", rdata, 0);
    check("reset rvalid", rvalid, 0);
    check_fields();
    read_all();
  endtask

  // hang guard
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  // main sequence
  initial
  begin
    do_reset();
    // outputs never go low: enables must hold
    @(posedge clk_in);
    phase_mode <= 2'h0;
    // let the last low phase drain through the synchroniser first
    repeat (4) @(posedge clk_in);
    wr_byte(7'h02, 8'h00, 1'b0);
    wr_byte(7'h04, 8'h00, 1'b0);
    wr_byte(7'h08, 8'h00, 1'b0);
    repeat (8) @(posedge clk_in);
    #1;
    check("held enables", oe, 9'h1FF);
    @(posedge clk_in);
    phase_mode <= 2'h2;
    wait_oe();
    // aux code held while select is 1, taken while 0
    wr_byte(7'h01, 8'h1E, 1'b1);
    wr_byte(7'h01, 8'h54, 1'b0);
    // every test and amplitude combination
    for (int c = 0; c < 32; c++)
      wr_byte(7'h09, c[7:0], 1'b0);
    // write and read in one cycle: read returns the old byte
    @(posedge clk_in);
    wr <= 1'b1;
    rd <= 1'b1;
    idx <= 7'h09;
    wdata <= 8'h05;
    @(posedge clk_in);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    check("old byte", rdata, m[9]);
    m[9] = (m[9] & ~8'h1F) | 8'h05;
    // reserved and identity bytes ignore writes
    wr_byte(7'h03, 8'h00, 1'b0);
    wr_byte(7'h05, 8'hFF, 1'b0);
    wr_byte(7'h07, 8'h00, 1'b0);
    read_all();
    // random bytes to mapped and unmapped indices
    repeat (150)
    begin
      rv = $random(seed);
      wr_byte({3'h0, rv[3:0]}, rv[11:4], rv[12]);
    end
    wait_oe();
    read_all();
    do_reset();
    tally_and_finish();
  end
endmodule
